/* File: testbench/clcd_host_model.sv */
// Host processor model on the parallel bus of the display controller.
`timescale 1ns/100ps
module clcd_host_model
  import clcd_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Device bus
  output clcd_pkg::clcd_host_s host_o,
  input wire logic [7:0] db_i,
  // Read results
  output logic rd_stb_o,
  output logic [7:0] rd_val_o
);
  initial
  begin
    host_o = '0;
    rd_stb_o = 1'b0;
    rd_val_o = 8'h00;
  end

  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      input logic chk, output logic [7:0] q);
    @(negedge clock_i);
    host_o.rs = rs;
    host_o.rw = rw;
    if (!rw)
      host_o.db = d;
    host_o.en = 1'b1;
    // The strobe must outlast both synchroniser stages and the output register.
    repeat (5) @(negedge clock_i);
    q = db_i;
    host_o.en = 1'b0;
    rd_val_o = q;
    rd_stb_o = chk;
    @(negedge clock_i);
    rd_stb_o = 1'b0;
    repeat (4) @(negedge clock_i);
    // A released bus does not keep its last byte.
    host_o.db = ~host_o.db;
  endtask

  task automatic wait_idle();
    logic [7:0] s;
    s = 8'h80;
    for (int n = 0; n < 100 && s[7] !== 1'b0; n++)
      xfer(1'b0, 1'b1, 8'h00, 1'b0, s);
  endtask
endmodule

/* File: testbench/clcd_host_port_chk.sv */
// Port-level assertions for the character display host port.
`timescale 1ns/100ps
module clcd_host_port_chk
  import clcd_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Watched ports
  input wire logic host_port_sel_b1_i,
  input wire logic host_port_sel_b0_i,
  input wire clcd_pkg::clcd_host_s host_i,
  input wire logic [7:0] db_o,
  input wire logic db_oe_o,
  input wire clcd_pkg::clcd_lcd_s lcd_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  logic par;
  logic st_rd;
  logic dt_rd;
  assign par = !host_port_sel_b1_i && !host_port_sel_b0_i;
  assign st_rd = par && host_i.en && host_i.rw && !host_i.rs;
  assign dt_rd = par && host_i.en && host_i.rw && host_i.rs;

  a_oe_needs_read: assert property (
    db_oe_o |-> ($past(host_i.en, 2) && $past(host_i.rw, 2))
      || ($past(host_i.en, 3) && $past(host_i.rw, 3)))
    else $error("bus driven without a read strobe");
  a_oe_follows_read: assert property (
    (par && host_i.en && host_i.rw)[*5] |-> db_oe_o)
    else $error("read strobe not answered");
  a_oe_drop: assert property (
    (!host_i.en)[*4] |-> !db_oe_o)
    else $error("bus still driven after strobe");
  a_write_no_oe: assert property (
    (!host_i.rw)[*4] |-> !db_oe_o)
    else $error("bus driven during a write");
  a_oe_off_serial: assert property (
    (!par)[*4] |-> !db_oe_o)
    else $error("bus driven outside parallel mode");
  a_com_onehot: assert property (
    $onehot0(lcd_o.com))
    else $error("more than one common active");
  a_read_stable: assert property (
    dt_rd[*5] |-> $stable(db_o))
    else $error("data register moved during a read");
  a_busy_no_rise: assert property (
    st_rd[*5] |-> !$rose(db_o[7]))
    else $error("busy rose with no write");

  cover property (st_rd ##1 db_o[7]);
  cover property (dt_rd[*5]);
  cover property (!par && host_i.en);
endmodule

bind clcd_host_port clcd_host_port_chk u_chk (
  .clock_i(clock_i),
  .nrst_i(nrst_i),
  .host_port_sel_b1_i(host_port_sel_b1_i),
  .host_port_sel_b0_i(host_port_sel_b0_i),
  .host_i(host_i),
  .db_o(db_o),
  .db_oe_o(db_oe_o),
  .lcd_o(lcd_o)
);

/* File: testbench/tb_top.sv */
// Self-checking bench for the character display host port.
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module tb_top;
  import clcd_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] sel = 2'b00;
  clcd_host_s host;
  logic [7:0] db;
  logic db_oe;
  clcd_lcd_s lcd;
  logic rd_stb;
  logic [7:0] rd_val;
  logic [7:0] exp_q[$];
  logic [7:0] wd[4];
  logic [7:0] gd[8];
  logic [7:0] r;
  int errors = 0;
  int comparisons = 0;
  int seed = 82;

  always #2 clock_i = ~clock_i;

  clcd_host_port #(
    .EXEC_CYCLES(20),
    .CLEAR_CYCLES(200),
    .BLINK_CYCLES(64)
  ) dut (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .host_port_sel_b1_i(sel[1]),
    .host_port_sel_b0_i(sel[0]),
    .host_i(host),
    .db_o(db),
    .db_oe_o(db_oe),
    .lcd_o(lcd)
  );

  clcd_host_model cpu (
    .clock_i(clock_i),
    .host_o(host),
    .db_i(db),
    .rd_stb_o(rd_stb),
    .rd_val_o(rd_val)
  );

  task automatic give_verdict();
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic ins(input logic [7:0] c);
    cpu.wait_idle();
    cpu.xfer(1'b0, 1'b0, c, 1'b0, r);
  endtask

  task automatic wr(input logic [7:0] d);
    cpu.wait_idle();
    cpu.xfer(1'b1, 1'b0, d, 1'b0, r);
  endtask

  task automatic rd_chk(input logic rs, input logic [7:0] e);
    exp_q.push_back(e);
    cpu.xfer(rs, 1'b1, 8'h00, 1'b1, r);
  endtask

  always @(posedge clock_i)
  begin
    if (rd_stb === 1'b1 && exp_q.size() > 0)
    begin
      `CHK(rd_val, exp_q[0])
      void'(exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (10) @(negedge clock_i);
    nrst_i = 1'b1;
    rd_chk(1'b0, 8'h00);
    ins(8'h01);
    rd_chk(1'b0, 8'h80);
    ins(8'h85);
    for (int i = 0; i < 4; i++)
    begin
      wd[i] = 8'($random(seed));
      wr(wd[i]);
    end
    cpu.xfer(1'b0, 1'b0, 8'h80, 1'b0, r);
    cpu.wait_idle();
    rd_chk(1'b0, 8'h09);
    ins(8'h85);
    for (int i = 0; i < 4; i++)
      rd_chk(1'b1, wd[i]);
    rd_chk(1'b1, 8'h20);
    cpu.wait_idle();
    rd_chk(1'b0, 8'h0a);
    ins(8'h14);
    ins(8'h18);
    cpu.wait_idle();
    rd_chk(1'b0, 8'h0b);
    ins(8'h04);
    ins(8'h90);
    wr(8'h5a);
    cpu.wait_idle();
    rd_chk(1'b0, 8'h0f);
    ins(8'h06);
    ins(8'h38);
    ins(8'ha7);
    wr(8'h11);
    cpu.wait_idle();
    rd_chk(1'b0, 8'h40);
    ins(8'he7);
    wr(8'h22);
    cpu.wait_idle();
    rd_chk(1'b0, 8'h00);
    ins(8'h48);
    for (int i = 0; i < 8; i++)
    begin
      gd[i] = 8'($random(seed)) & 8'h1f;
      wr(gd[i]);
    end
    cpu.wait_idle();
    rd_chk(1'b0, 8'h10);
    ins(8'h48);
    for (int i = 0; i < 8; i++)
      rd_chk(1'b1, gd[i]);
    ins(8'h85);
    rd_chk(1'b1, wd[0]);
    // Four-bit bus: every byte is two transfers, high nibble first.
    ins(8'h28);
    repeat (30) @(negedge clock_i);
    cpu.xfer(1'b0, 1'b0, 8'h80, 1'b0, r);
    cpu.xfer(1'b0, 1'b0, 8'h50, 1'b0, r);
    repeat (30) @(negedge clock_i);
    rd_chk(1'b0, 8'h00);
    rd_chk(1'b0, 8'h50);
    rd_chk(1'b1, {wd[0][7:4], 4'h0});
    rd_chk(1'b1, {wd[0][3:0], 4'h0});
    cpu.xfer(1'b0, 1'b0, 8'h30, 1'b0, r);
    cpu.xfer(1'b0, 1'b0, 8'h80, 1'b0, r);
    repeat (30) @(negedge clock_i);
    `CHK(lcd.com, 16'h0000)
    `CHK(lcd.seg, 40'h0)
    ins(8'h0f);
    ins(8'h83);
    sel = 2'b11;
    repeat (4) @(negedge clock_i);
    cpu.xfer(1'b1, 1'b0, 8'hff, 1'b0, r);
    cpu.xfer(1'b0, 1'b1, 8'h00, 1'b0, r);
    sel = 2'b00;
    repeat (4) @(negedge clock_i);
    cpu.wait_idle();
    rd_chk(1'b0, 8'h03);
    ins(8'h02);
    cpu.wait_idle();
    rd_chk(1'b0, 8'h00);
    repeat (200) @(negedge clock_i);
    `CHK(lcd.com != 16'h0000, 1'b1)
    give_verdict();
  end

  // The sequence needs a few thousand cycles; ten times that means a hang.
  initial
  begin
    #100000;
    errors++;
    give_verdict();
  end
endmodule

/* File: verilog/clcd_dpram.sv */
// Two-port memory with registered read data, one read/write port and one read port.
`timescale 1ns/100ps
module clcd_dpram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 80,
  parameter int AW = 7
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Host port
  input wire logic a_we_i,
  input wire logic [AW-1:0] a_addr_i,
  input wire logic [WIDTH-1:0] a_wdata_i,
  output logic [WIDTH-1:0] a_rdata_o,
  // Scan port
  input wire logic [AW-1:0] b_addr_i,
  output logic [WIDTH-1:0] b_rdata_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  generate
    if (DEPTH > (1 << AW))
    begin : g_bad_depth
      $error("clcd_dpram depth does not fit the address width");
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (a_we_i && int'(a_addr_i) < DEPTH)
    begin
      mem_r[a_addr_i] <= a_wdata_i;
    end
  end

  // Out of range addresses read as zero rather than an undefined word.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      a_rdata_o <= '0;
      b_rdata_o <= '0;
    end
    else
    begin
      a_rdata_o <= (int'(a_addr_i) < DEPTH) ? mem_r[a_addr_i] : '0;
      b_rdata_o <= (int'(b_addr_i) < DEPTH) ? mem_r[b_addr_i] : '0;
    end
  end

endmodule

/* File: verilog/clcd_host_port.sv */
// Character display controller: parallel host port, text and glyph memories, scan drive.
`timescale 1ns/100ps
module clcd_host_port
  import clcd_pkg::*;
#(
  parameter int EXEC_CYCLES = clcd_pkg::EXEC_CYC,
  parameter int CLEAR_CYCLES = clcd_pkg::CLEAR_CYC,
  parameter int BLINK_CYCLES = clcd_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Interface select pins
  input wire logic host_port_sel_b1_i,
  input wire logic host_port_sel_b0_i,
  // Parallel host bus
  input wire clcd_pkg::clcd_host_s host_i,
  output logic [7:0] db_o,
  output logic db_oe_o,
  // Display drive
  output clcd_pkg::clcd_lcd_s lcd_o
);
  import clcd_pkg::*;

  clcd_state_s s_r;
  clcd_state_s s_nxt;
  logic parallel;
  logic busy;
  logic fall;
  logic done;
  logic [7:0] byte_in;
  logic [7:0] stat_val;
  logic a_we;
  logic [6:0] text_a_addr;
  logic [6:0] text_b_addr;
  logic [5:0] glyph_b_addr;
  logic [7:0] text_rd_a;
  logic [7:0] text_rd_b;
  logic [4:0] glyph_rd_a;
  logic [4:0] glyph_rd_b;
  logic [6:0] vis;
  logic [4:0] px;
  logic [3:0] com_idx;

  generate
    if (EXEC_CYCLES < 1 || CLEAR_CYCLES < 1 || CLEAR_CYCLES >= (1 << BUSY_W)
        || EXEC_CYCLES >= (1 << BUSY_W) || BLINK_CYCLES < 1
        || BLINK_CYCLES >= (1 << BLINK_W))
    begin : g_bad_param
      $error("clcd_host_port timing parameter out of range");
    end
  endgenerate

  // Logical text address to physical RAM index; line two follows line one in RAM.
  function automatic logic [6:0] phys_idx(input logic [6:0] a);
    return (a >= LINE2_BASE) ? 7'(a - LINE2_BASE + 7'(LINE_LEN)) : a;
  endfunction

  function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                         input logic two, input logic glyph);
    logic [6:0] r;
    r = up ? 7'(a + 7'h1) : 7'(a - 7'h1);
    if (glyph)
      r = {1'b0, r[5:0]};
    else if (two && up && a == LINE1_LAST)
      r = LINE2_BASE;
    else if (two && up && a == LINE2_LAST)
      r = 7'h00;
    else if (two && !up && a == 7'h00)
      r = LINE2_LAST;
    else if (two && !up && a == LINE2_BASE)
      r = LINE1_LAST;
    else if (!two && up && a == ONE_LINE_LAST)
      r = 7'h00;
    else if (!two && !up && a == 7'h00)
      r = ONE_LINE_LAST;
    return r;
  endfunction

  function automatic logic [6:0] sh_step(input logic [6:0] sh, input logic up,
                                         input logic two);
    logic [6:0] last;
    last = two ? 7'(LINE_LEN - 1) : 7'(TEXT_RAM_DEPTH - 1);
    if (up)
      return (sh >= last) ? 7'h00 : 7'(sh + 7'h1);
    return (sh == 7'h00) ? last : 7'(sh - 7'h1);
  endfunction

  function automatic logic [6:0] vis_addr(input logic ln, input logic [2:0] c,
                                          input logic [6:0] sh, input logic two);
    logic [7:0] sum;
    logic [7:0] len;
    sum = 8'(c) + 8'(sh);
    len = two ? 8'(LINE_LEN) : 8'(TEXT_RAM_DEPTH);
    if (sum >= len)
      sum = 8'(sum - len);
    return (two && ln) ? 7'(LINE2_BASE + sum[6:0]) : sum[6:0];
  endfunction

  // Built-in glyph shapes are a generated stand-in pattern, not a real font.
  function automatic logic [4:0] rom_row(input logic [7:0] c, input logic [2:0] r);
    return (r == CURSOR_ROW) ? 5'h00 : 5'(c[4:0] ^ {r, c[7:6]});
  endfunction

  clcd_dpram #(.WIDTH(8), .DEPTH(TEXT_RAM_DEPTH), .AW(7)) u_text_ram (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .a_we_i(a_we & (s_r.clearing | ~s_r.ram_glyph)),
    .a_addr_i(text_a_addr),
    .a_wdata_i(s_r.clearing ? SPACE_CODE : byte_in),
    .a_rdata_o(text_rd_a),
    .b_addr_i(text_b_addr),
    .b_rdata_o(text_rd_b)
  );

  clcd_dpram #(.WIDTH(GLYPH_COLS), .DEPTH(GLYPH_RAM_DEPTH), .AW(6)) u_glyph_ram (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .a_we_i(a_we & s_r.ram_glyph & ~s_r.clearing),
    .a_addr_i(s_r.ac[5:0]),
    .a_wdata_i(byte_in[GLYPH_COLS-1:0]),
    .a_rdata_o(glyph_rd_a),
    .b_addr_i(glyph_b_addr),
    .b_rdata_o(glyph_rd_b)
  );

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pin_m = host_i;
    s_nxt.pin_s = s_r.pin_m;
    s_nxt.en_d = s_r.pin_s.en;
    s_nxt.sel_m = {host_port_sel_b1_i, host_port_sel_b0_i};
    s_nxt.sel_s = s_r.sel_m;
    parallel = (s_r.sel_s == HOST_SEL_PARALLEL);
    busy = (s_r.busy_cnt != '0);
    fall = parallel & s_r.en_d & ~s_r.pin_s.en;
    done = fall & (s_r.width8 | s_r.nib_hi);
    byte_in = s_r.width8 ? s_r.pin_s.db : {s_r.nib_buf, s_r.pin_s.db[7:4]};
    a_we = 1'b0;
    text_a_addr = s_r.clearing ? s_r.clr_cnt : phys_idx(s_r.ac);
    if (busy)
      s_nxt.busy_cnt = BUSY_W'(s_r.busy_cnt - 1'b1);
    // In 4-bit mode the high nibble travels first on the upper data lines.
    if (fall && !s_r.width8)
    begin
      s_nxt.nib_hi = ~s_r.nib_hi;
      s_nxt.nib_buf = s_r.pin_s.db[7:4];
    end
    // prefetched word lands in the data register.
    if (s_r.cap)
    begin
      s_nxt.dr = s_r.ram_glyph ? {3'h0, glyph_rd_a} : text_rd_a;
      s_nxt.cap = 1'b0;
    end
    if (s_r.clearing)
    begin
      a_we = 1'b1;
      s_nxt.clr_cnt = 7'(s_r.clr_cnt + 7'h1);
      if (s_r.clr_cnt == CLEAR_LAST)
        s_nxt.clearing = 1'b0;
    end
    else if (done && !s_r.pin_s.rs && !s_r.pin_s.rw && !busy)
    begin
      s_nxt.ir = byte_in;
      s_nxt.busy_cnt = BUSY_W'(EXEC_CYCLES);
      if (byte_in[INS_DDADDR_BIT])
      begin
        s_nxt.ac = byte_in[6:0];
        s_nxt.ram_glyph = 1'b0;
        s_nxt.fetch = 1'b1;
      end
      else if (byte_in[INS_CGADDR_BIT])
      begin
        s_nxt.ac = {1'b0, byte_in[5:0]};
        s_nxt.ram_glyph = 1'b1;
        s_nxt.fetch = 1'b1;
      end
      else if (byte_in[INS_FUNC_BIT])
      begin
        s_nxt.width8 = byte_in[FUNC_DL_BIT];
        s_nxt.two_line = byte_in[FUNC_N_BIT];
        s_nxt.shift = 7'h00;
        s_nxt.nib_hi = 1'b0;
      end
      else if (byte_in[INS_SHIFT_BIT])
      begin
        if (byte_in[SHIFT_SC_BIT])
          s_nxt.shift = sh_step(s_r.shift, ~byte_in[SHIFT_RL_BIT], s_r.two_line);
        else
          s_nxt.ac = ac_step(s_r.ac, byte_in[SHIFT_RL_BIT], s_r.two_line, s_r.ram_glyph);
      end
      else if (byte_in[INS_DISP_BIT])
      begin
        s_nxt.disp_on = byte_in[DISP_D_BIT];
        s_nxt.cur_on = byte_in[DISP_C_BIT];
        s_nxt.blink_on = byte_in[DISP_B_BIT];
      end
      else if (byte_in[INS_ENTRY_BIT])
      begin
        s_nxt.inc = byte_in[ENTRY_ID_BIT];
        s_nxt.shift_on_write = byte_in[ENTRY_SH_BIT];
      end
      else if (byte_in[INS_HOME_BIT] || byte_in[INS_CLEAR_BIT])
      begin
        s_nxt.ac = 7'h00;
        s_nxt.shift = 7'h00;
        s_nxt.ram_glyph = 1'b0;
        s_nxt.busy_cnt = BUSY_W'(CLEAR_CYCLES);
        s_nxt.fetch = 1'b1;
        if (!byte_in[INS_HOME_BIT])
        begin
          s_nxt.clearing = 1'b1;
          s_nxt.clr_cnt = 7'h00;
          s_nxt.inc = RST_INC;
        end
      end
    end
    else if (done && s_r.pin_s.rs && !s_r.pin_s.rw && !busy)
    begin
      a_we = 1'b1;
      s_nxt.dr = byte_in;
      s_nxt.busy_cnt = BUSY_W'(EXEC_CYCLES);
      s_nxt.ac = ac_step(s_r.ac, s_r.inc, s_r.two_line, s_r.ram_glyph);
      if (s_r.shift_on_write && !s_r.ram_glyph)
        s_nxt.shift = sh_step(s_r.shift, s_r.inc, s_r.two_line);
    end
    else if (done && s_r.pin_s.rs && s_r.pin_s.rw)
    begin
      s_nxt.ac = ac_step(s_r.ac, s_r.inc, s_r.two_line, s_r.ram_glyph);
      s_nxt.fetch = 1'b1;
    end
    else if (s_r.fetch)
    begin
      s_nxt.fetch = 1'b0;
      s_nxt.cap = 1'b1;
    end
    // status word; the instruction code is never a read source.
    stat_val = {busy, s_r.ac};
    if (s_r.pin_s.rs)
      stat_val = s_r.dr;
    if (s_r.width8)
      s_nxt.db_out = stat_val;
    else
      s_nxt.db_out = s_r.nib_hi ? {stat_val[3:0], 4'h0} : {stat_val[7:4], 4'h0};

    if (s_r.blink_cnt >= BLINK_W'(BLINK_CYCLES - 1))
    begin
      s_nxt.blink_cnt = '0;
      s_nxt.blink_ph = ~s_r.blink_ph;
    end
    else
      s_nxt.blink_cnt = BLINK_W'(s_r.blink_cnt + 1'b1);

    vis = vis_addr(s_r.line, s_r.col, s_r.shift, s_r.two_line);
    text_b_addr = phys_idx(vis);
    glyph_b_addr = {text_rd_b[2:0], s_r.row};
    px = glyph_rd_b;
    com_idx = {s_r.line, s_r.row};
    case (s_r.scan)
      SCAN_TEXT:
        s_nxt.scan = SCAN_CODE;
      SCAN_CODE:
      begin
        s_nxt.code = text_rd_b;
        s_nxt.scan = SCAN_GLYPH;
      end
      SCAN_GLYPH:
      begin
        if (s_r.code[USER_GLYPH_HI:USER_GLYPH_LO] != 4'h0)
          px = rom_row(s_r.code, s_r.row);
        if (s_r.cur_on && !s_r.ram_glyph && vis == s_r.ac && s_r.row == CURSOR_ROW)
          px = px | 5'h1f;
        if (s_r.blink_on && s_r.blink_ph && !s_r.ram_glyph && vis == s_r.ac)
          px = ~px;
        s_nxt.pix = px;
        s_nxt.bit_cnt = 3'h0;
        s_nxt.scan = SCAN_SHIFT;
      end
      SCAN_SHIFT:
      begin
        s_nxt.chain = {s_r.chain[SEG_COUNT-2:0], s_r.pix[3'(GLYPH_COLS - 1) - s_r.bit_cnt]};
        s_nxt.bit_cnt = 3'(s_r.bit_cnt + 3'h1);
        if (s_r.bit_cnt == 3'(GLYPH_COLS - 1))
        begin
          s_nxt.col = 3'(s_r.col + 3'h1);
          s_nxt.scan = (s_r.col == 3'(VIS_CHARS - 1)) ? SCAN_LATCH : SCAN_TEXT;
        end
      end
      SCAN_LATCH:
      begin
        s_nxt.lcd.seg = s_r.disp_on ? s_r.chain : '0;
        s_nxt.lcd.com = '0;
        s_nxt.lcd.com[com_idx] = s_r.disp_on;
        s_nxt.row = 3'(s_r.row + 3'h1);
        if (s_r.row == 3'(GLYPH_ROWS - 1))
          s_nxt.line = s_r.two_line & ~s_r.line;
        s_nxt.scan = SCAN_TEXT;
      end
      default:
        s_nxt.scan = SCAN_TEXT;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_r <= '0;
      s_r.inc <= RST_INC;
      s_r.width8 <= RST_WIDTH8;
      s_r.two_line <= RST_TWO_LINE;
      s_r.disp_on <= RST_DISP_ON;
      s_r.scan <= SCAN_TEXT;
    end
    else
      s_r <= s_nxt;
  end

  // the bus is only driven in parallel mode
  assign db_oe_o = parallel & s_r.pin_s.en & s_r.pin_s.rw;
  assign db_o = s_r.db_out;
  assign lcd_o = s_r.lcd;

endmodule

/* File: verilog/clcd_pkg.sv */
// Shared constants, types and state layout of the character display host port.
package clcd_pkg;

  // Clock and instruction execution times.
  localparam int CLK_PERIOD_NS = 4;
  localparam int EXEC_TIME_NS = 18500;
  localparam int CLEAR_TIME_NS = 760000;
  localparam int EXEC_CYC = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_CYC = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_HALF_CYC = 4000000;
  localparam int BUSY_W = 20;
  localparam int BLINK_W = 24;

  // Memory organisation.
  localparam int TEXT_RAM_DEPTH = 80;
  localparam int LINE_LEN = 40;
  localparam int GLYPH_RAM_DEPTH = 64;
  localparam int GLYPH_COLS = 5;
  localparam int GLYPH_ROWS = 8;
  localparam int GLYPH_COUNT = 256;
  localparam int GLYPH_ROM_BITS = GLYPH_COUNT * GLYPH_COLS * GLYPH_ROWS;
  localparam int VIS_CHARS = 8;
  localparam int SEG_COUNT = 40;
  localparam int COM_COUNT = 16;

  // Display text address map.
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
  localparam logic [6:0] CLEAR_LAST = 7'h4f;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [2:0] CURSOR_ROW = 3'h7;

  // Instruction opcode bits, highest set bit selects the instruction.
  localparam int INS_DDADDR_BIT = 7;
  localparam int INS_CGADDR_BIT = 6;
  localparam int INS_FUNC_BIT = 5;
  localparam int INS_SHIFT_BIT = 4;
  localparam int INS_DISP_BIT = 3;
  localparam int INS_ENTRY_BIT = 2;
  localparam int INS_HOME_BIT = 1;
  localparam int INS_CLEAR_BIT = 0;
  localparam int ENTRY_ID_BIT = 1;
  localparam int ENTRY_SH_BIT = 0;
  localparam int DISP_D_BIT = 2;
  localparam int DISP_C_BIT = 1;
  localparam int DISP_B_BIT = 0;
  localparam int SHIFT_SC_BIT = 3;
  localparam int SHIFT_RL_BIT = 2;
  localparam int FUNC_DL_BIT = 4;
  localparam int FUNC_N_BIT = 3;
  localparam int USER_GLYPH_HI = 7;
  localparam int USER_GLYPH_LO = 4;

  // Interface select pin code for the parallel bus.
  localparam logic [1:0] HOST_SEL_PARALLEL = 2'b00;

  // Reset values.
  localparam logic RST_INC = 1'b1;
  localparam logic RST_WIDTH8 = 1'b1;
  localparam logic RST_TWO_LINE = 1'b0;
  localparam logic RST_DISP_ON = 1'b0;

  typedef enum logic [2:0] {
    SCAN_TEXT,
    SCAN_CODE,
    SCAN_GLYPH,
    SCAN_SHIFT,
    SCAN_LATCH
  } clcd_scan_e;

  typedef struct packed {
    logic rs;
    logic rw;
    logic en;
    logic [7:0] db;
  } clcd_host_s;

  typedef struct packed {
    logic [COM_COUNT-1:0] com;
    logic [SEG_COUNT-1:0] seg;
  } clcd_lcd_s;

  typedef struct packed {
    clcd_host_s pin_m;
    clcd_host_s pin_s;
    logic en_d;
    logic [1:0] sel_m;
    logic [1:0] sel_s;
    logic [7:0] ir;
    logic [7:0] dr;
    logic [6:0] ac;
    logic ram_glyph;
    logic inc;
    logic shift_on_write;
    logic disp_on;
    logic cur_on;
    logic blink_on;
    logic width8;
    logic two_line;
    logic [6:0] shift;
    logic [BUSY_W-1:0] busy_cnt;
    logic clearing;
    logic [6:0] clr_cnt;
    logic nib_hi;
    logic [3:0] nib_buf;
    logic fetch;
    logic cap;
    logic [7:0] db_out;
    clcd_scan_e scan;
    logic [2:0] col;
    logic [2:0] row;
    logic line;
    logic [2:0] bit_cnt;
    logic [7:0] code;
    logic [4:0] pix;
    logic [SEG_COUNT-1:0] chain;
    clcd_lcd_s lcd;
    logic [BLINK_W-1:0] blink_cnt;
    logic blink_ph;
  } clcd_state_s;

endpackage
